/* pkg/cef_pkg.sv */
// Constants and types for the CAN event flag register block
package cef_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Bus widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FLAG_W = 8;
    localparam int MODE_W = 2;
    localparam int ERR_SRC_W = 4;
    localparam int TX_BUF_W = 3;
    localparam int RX_BUF_W = 2;
    localparam int PRG_BUF_W = 6;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_MASK = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_PEND = 12'h00C;

    ////////////////////////////////////////////////////////////////////////
    // Flag bit positions
    localparam int BIT_INVALID = 7;
    localparam int BIT_WAKE = 6;
    localparam int BIT_ERR = 5;
    localparam int BIT_TX2 = 4;
    localparam int BIT_TX1 = 3;
    localparam int BIT_TX0 = 2;
    localparam int BIT_RX1 = 1;
    localparam int BIT_RX0 = 0;

    // Control register field: operating mode in the low bits
    localparam int CTRL_MODE_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [FLAG_W-1:0] RST_FLAGS = 8'h00;
    localparam logic [FLAG_W-1:0] RST_MASK = 8'h00;

    // Mode codes as seen by software
    localparam logic [MODE_W-1:0] MODE_LEGACY = 2'h0;
    localparam logic [MODE_W-1:0] MODE_ENH = 2'h1;
    localparam logic [MODE_W-1:0] MODE_FIFO = 2'h2;

    // Implemented flag bits per mode
    localparam logic [FLAG_W-1:0] IMPL_LEGACY = 8'hFF;
    localparam logic [FLAG_W-1:0] IMPL_ENH = 8'hF2;
    localparam logic [FLAG_W-1:0] IMPL_FIFO = 8'hF3;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        CEF_M_LEGACY = 3'b001,
        CEF_M_ENH = 3'b010,
        CEF_M_FIFO = 3'b100
    } cef_mode_t;

    typedef enum logic [4:0] {
        CEF_SEL_NONE = 5'b00001,
        CEF_SEL_FLAGS = 5'b00010,
        CEF_SEL_MASK = 5'b00100,
        CEF_SEL_CTRL = 5'b01000,
        CEF_SEL_PEND = 5'b10000
    } cef_sel_t;

endpackage

/* src/cef_flag_reg.sv */
// CAN event flag register with APB slave and interrupt output
`timescale 1ns/100ps

module cef_flag_reg (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    // APB slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [cef_pkg::ADDR_W-1:0] I_PADDR,
    input wire logic [cef_pkg::DATA_W-1:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [cef_pkg::DATA_W-1:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // Event strobes from the CAN controller, same clock
    input wire logic I_INVALID_MSG,
    input wire logic I_BUS_WAKE,
    input wire logic [cef_pkg::ERR_SRC_W-1:0] I_MODULE_ERR,
    input wire logic [cef_pkg::TX_BUF_W-1:0] I_TX_DONE,
    input wire logic [cef_pkg::RX_BUF_W-1:0] I_RX_NEW,
    input wire logic [cef_pkg::PRG_BUF_W-1:0] I_PRG_TX_DONE,
    input wire logic [cef_pkg::PRG_BUF_W-1:0] I_PRG_RX_NEW,
    input wire logic I_FIFO_WM,
    // Flag state and interrupt
    output logic [cef_pkg::FLAG_W-1:0] O_CAN_IRQ_FLAGS,
    output logic [cef_pkg::MODE_W-1:0] O_CAN_MODE,
    output logic O_IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [cef_pkg::FLAG_W-1:0] can_irq_flags;
        logic [cef_pkg::FLAG_W-1:0] mask;
        cef_pkg::cef_mode_t mode;
        logic [cef_pkg::DATA_W-1:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
    } cef_state_t;

    localparam cef_state_t RST_STATE = '{
        can_irq_flags: cef_pkg::RST_FLAGS,
        mask: cef_pkg::RST_MASK,
        mode: cef_pkg::CEF_M_LEGACY,
        rdata: 32'h0000_0000,
        ready: 1'b0,
        slverr: 1'b0,
        irq: 1'b0
    };

    cef_state_t s_q;
    cef_state_t s_d;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Word-aligned address decode, shared by read and write paths
    function automatic cef_pkg::cef_sel_t reg_sel(
        input logic [cef_pkg::ADDR_W-1:0] addr
    );
        cef_pkg::cef_sel_t sel;
        sel = cef_pkg::CEF_SEL_NONE;
        if (addr == cef_pkg::OFF_FLAGS) begin
            sel = cef_pkg::CEF_SEL_FLAGS;
        end else if (addr == cef_pkg::OFF_MASK) begin
            sel = cef_pkg::CEF_SEL_MASK;
        end else if (addr == cef_pkg::OFF_CTRL) begin
            sel = cef_pkg::CEF_SEL_CTRL;
        end else if (addr == cef_pkg::OFF_PEND) begin
            sel = cef_pkg::CEF_SEL_PEND;
        end
        return sel;
    endfunction

    // Bits that exist in a given mode; the rest read and hold zero
    function automatic logic [cef_pkg::FLAG_W-1:0] impl_bits(
        input cef_pkg::cef_mode_t m
    );
        logic [cef_pkg::FLAG_W-1:0] b;
        b = cef_pkg::IMPL_LEGACY;
        unique case (m)
            cef_pkg::CEF_M_LEGACY: begin
                b = cef_pkg::IMPL_LEGACY;
            end
            cef_pkg::CEF_M_ENH: begin
                b = cef_pkg::IMPL_ENH;
            end
            cef_pkg::CEF_M_FIFO: begin
                b = cef_pkg::IMPL_FIFO;
            end
        endcase
        return b;
    endfunction

    // Mode as a software code
    function automatic logic [cef_pkg::MODE_W-1:0] mode_code(
        input cef_pkg::cef_mode_t m
    );
        logic [cef_pkg::MODE_W-1:0] c;
        c = cef_pkg::MODE_LEGACY;
        unique case (m)
            cef_pkg::CEF_M_LEGACY: begin
                c = cef_pkg::MODE_LEGACY;
            end
            cef_pkg::CEF_M_ENH: begin
                c = cef_pkg::MODE_ENH;
            end
            cef_pkg::CEF_M_FIFO: begin
                c = cef_pkg::MODE_FIFO;
            end
        endcase
        return c;
    endfunction

    // Software code to mode; the reserved code keeps the current mode
    function automatic cef_pkg::cef_mode_t code_to_mode(
        input logic [cef_pkg::MODE_W-1:0] c,
        input cef_pkg::cef_mode_t cur
    );
        cef_pkg::cef_mode_t m;
        m = cur;
        if (c == cef_pkg::MODE_LEGACY) begin
            m = cef_pkg::CEF_M_LEGACY;
        end else if (c == cef_pkg::MODE_ENH) begin
            m = cef_pkg::CEF_M_ENH;
        end else if (c == cef_pkg::MODE_FIFO) begin
            m = cef_pkg::CEF_M_FIFO;
        end
        return m;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Events common to all modes, and buffer summaries used by the enhanced and FIFO modes

    logic [cef_pkg::FLAG_W-1:0] ev;
    logic ev_invalid;
    logic ev_wake;
    logic ev_err;
    logic any_tx;
    logic any_rx;

    assign ev_invalid = I_INVALID_MSG;
    assign ev_wake = I_BUS_WAKE;
    // Any one error source is enough
    assign ev_err = |I_MODULE_ERR;
    // Dedicated and programmable buffers both count
    assign any_tx = (|I_TX_DONE) | (|I_PRG_TX_DONE);
    assign any_rx = (|I_RX_NEW) | (|I_PRG_RX_NEW);

    ////////////////////////////////////////////////////////////////////////
    // Buffer events per mode

    always_comb begin
        ev = 8'h00;
        ev[cef_pkg::BIT_INVALID] = ev_invalid;
        ev[cef_pkg::BIT_WAKE] = ev_wake;
        ev[cef_pkg::BIT_ERR] = ev_err;
        unique case (s_q.mode)
            cef_pkg::CEF_M_LEGACY: begin
                ev[cef_pkg::BIT_TX2] = I_TX_DONE[2];
                ev[cef_pkg::BIT_TX1] = I_TX_DONE[1];
                ev[cef_pkg::BIT_TX0] = I_TX_DONE[0];
                ev[cef_pkg::BIT_RX1] = I_RX_NEW[1];
                ev[cef_pkg::BIT_RX0] = I_RX_NEW[0];
            end
            cef_pkg::CEF_M_ENH: begin
                ev[cef_pkg::BIT_TX2] = any_tx;
                ev[cef_pkg::BIT_RX1] = any_rx;
            end
            cef_pkg::CEF_M_FIFO: begin
                ev[cef_pkg::BIT_TX2] = any_tx;
                ev[cef_pkg::BIT_RX1] = any_rx;
                ev[cef_pkg::BIT_RX0] = I_FIFO_WM;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic access;
    logic commit;
    logic wr_lane0;
    logic wr_flags;
    logic wr_mask;
    logic wr_ctrl;
    cef_pkg::cef_sel_t sel;
    logic [cef_pkg::FLAG_W-1:0] wbyte;
    logic [cef_pkg::MODE_W-1:0] new_mode;

    always_comb begin
        access = I_PSEL & I_PENABLE;
        sel = reg_sel(I_PADDR);
        // Second access cycle, the one that sees ready high
        commit = access & s_q.ready;
        wr_lane0 = commit & I_PWRITE & I_PSTRB[0];
        // Writes to the pending word are dropped without error
        wr_flags = wr_lane0 & (sel == cef_pkg::CEF_SEL_FLAGS);
        wr_mask = wr_lane0 & (sel == cef_pkg::CEF_SEL_MASK);
        wr_ctrl = wr_lane0 & (sel == cef_pkg::CEF_SEL_CTRL);
        wbyte = I_PWDATA[cef_pkg::FLAG_W-1:0];
        new_mode = I_PWDATA[cef_pkg::CTRL_MODE_LSB +: cef_pkg::MODE_W];
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode selection

    cef_pkg::cef_mode_t mode_nx;

    always_comb begin
        mode_nx = s_q.mode;
        if (wr_ctrl) begin
            mode_nx = code_to_mode(new_mode, s_q.mode);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag update, one bit at a time

    logic [cef_pkg::FLAG_W-1:0] flags_base;
    logic [cef_pkg::FLAG_W-1:0] keep;
    logic [cef_pkg::FLAG_W-1:0] flags_nx;

    // Software write replaces the byte; old flags otherwise
    assign flags_base = wr_flags ? wbyte : s_q.can_irq_flags;
    // Bits missing in the new mode clear at once
    assign keep = impl_bits(mode_nx);

    generate
        for (genvar gi = 0; gi < cef_pkg::FLAG_W; gi++) begin : g_flag
            // A hardware event beats a same-cycle software clear
            assign flags_nx[gi] = (flags_base[gi] | ev[gi]) & keep[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data, captured in the first access cycle

    logic [cef_pkg::DATA_W-1:0] rd_word;

    always_comb begin
        // Upper bits read zero
        rd_word = 32'h0000_0000;
        if (~I_PWRITE) begin
            unique case (sel)
                cef_pkg::CEF_SEL_NONE: begin
                    rd_word = 32'h0000_0000;
                end
                cef_pkg::CEF_SEL_FLAGS: begin
                    rd_word[cef_pkg::FLAG_W-1:0] = s_q.can_irq_flags;
                end
                cef_pkg::CEF_SEL_MASK: begin
                    rd_word[cef_pkg::FLAG_W-1:0] = s_q.mask;
                end
                cef_pkg::CEF_SEL_CTRL: begin
                    rd_word[cef_pkg::MODE_W-1:0] = mode_code(s_q.mode);
                end
                cef_pkg::CEF_SEL_PEND: begin
                    rd_word[cef_pkg::FLAG_W-1:0] =
                        s_q.can_irq_flags & s_q.mask;
                end
                default: begin
                    rd_word = 32'h0000_0000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask and interrupt

    logic [cef_pkg::FLAG_W-1:0] mask_nx;
    logic [cef_pkg::FLAG_W-1:0] pend_nx;

    assign mask_nx = wr_mask ? wbyte : s_q.mask;
    // Taken from the next state, so it moves with the flags
    assign pend_nx = flags_nx & mask_nx;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        s_d = s_q;

        // Bus answer: one wait state, then completion
        if (access & ~s_q.ready) begin
            s_d.ready = 1'b1;
            // Unmapped address answers with an error
            s_d.slverr = (sel == cef_pkg::CEF_SEL_NONE);
            s_d.rdata = rd_word;
        end else begin
            // Answer stands one cycle, also if the master gives up
            s_d.ready = 1'b0;
            s_d.slverr = 1'b0;
            s_d.rdata = 32'h0000_0000;
        end

        // Register writes take effect at the completing edge
        s_d.mask = mask_nx;
        s_d.mode = mode_nx;
        s_d.can_irq_flags = flags_nx;
        s_d.irq = |pend_nx;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from the state register

    assign O_PRDATA = s_q.rdata;
    assign O_PREADY = s_q.ready;
    assign O_PSLVERR = s_q.slverr;
    assign O_CAN_IRQ_FLAGS = s_q.can_irq_flags;
    // One-hot mode bits 2 and 1 are the code bits
    assign O_CAN_MODE = {s_q.mode[2], s_q.mode[1]};
    assign O_IRQ = s_q.irq;

endmodule

/* tb/cef_flag_reg_chk.sv */
// Port assertions for the CAN event flag register
`timescale 1ns/100ps
module cef_flag_reg_chk (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic O_PREADY,
    input wire logic I_INVALID_MSG,
    input wire logic [cef_pkg::ERR_SRC_W-1:0] I_MODULE_ERR,
    input wire logic [cef_pkg::TX_BUF_W-1:0] I_TX_DONE,
    input wire logic [cef_pkg::PRG_BUF_W-1:0] I_PRG_TX_DONE,
    input wire logic I_FIFO_WM,
    input wire logic [cef_pkg::FLAG_W-1:0] O_CAN_IRQ_FLAGS,
    input wire logic [cef_pkg::MODE_W-1:0] O_CAN_MODE
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_SYS_RST);
    logic wr_done;
    assign wr_done = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
    ////////////////////////////////////////
    sequence s_access;
        I_PSEL && I_PENABLE && !O_PREADY;
    endsequence
    sequence s_wm_seen;
        O_CAN_MODE == 2'h2 && I_FIFO_WM ##1 O_CAN_MODE == 2'h2;
    endsequence
    a_one_wait: assert property (
        s_access |=> O_PREADY) else $error("ready late");
    a_ready_pulse: assert property (
        O_PREADY |=> !O_PREADY) else $error("ready held");
    a_invalid_set: assert property (
        I_INVALID_MSG |=> O_CAN_IRQ_FLAGS[7]) else $error("bit 7 missed");
    a_err_set: assert property (
        |I_MODULE_ERR |=> O_CAN_IRQ_FLAGS[5]) else $error("bit 5 missed");
    a_tx2_set: assert property (
        O_CAN_MODE == 2'h0 && I_TX_DONE[2] |=> O_CAN_IRQ_FLAGS[4])
        else $error("bit 4 missed");
    a_any_tx: assert property (
        O_CAN_MODE != 2'h0 && (|I_TX_DONE || |I_PRG_TX_DONE)
        |=> O_CAN_IRQ_FLAGS[4]) else $error("any tx missed");
    a_tx_forced: assert property (
        O_CAN_MODE != 2'h0 |-> O_CAN_IRQ_FLAGS[3:2] == 2'h0)
        else $error("bits 3:2 set");
    a_rx0_off: assert property (
        O_CAN_MODE == 2'h1 |-> !O_CAN_IRQ_FLAGS[0]) else $error("bit 0 set");
    a_fifo_wm: assert property (
        s_wm_seen |-> O_CAN_IRQ_FLAGS[0]) else $error("watermark missed");
    a_flag_sticky: assert property (
        O_CAN_IRQ_FLAGS[7] && !wr_done |=> O_CAN_IRQ_FLAGS[7])
        else $error("bit 7 lost");
endmodule

/* tb/cef_can_model.sv */
// Behavioural CAN controller firing event strobes
`timescale 1ns/100ps
module cef_can_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [23:0] i_ev,
    output logic [23:0] o_ev
);
    // One-cycle strobes, low between events
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ev <= 24'h000000;
        end else begin
            o_ev <= i_go ? i_ev : 24'h000000;
        end
    end
endmodule

/* tb/cef_flag_reg_tb_top.sv */
// Self-checking bench for the CAN event flag register
`timescale 1ns/100ps
module cef_flag_reg_tb_top;
    typedef struct {
        logic [1:0] m;
        logic [23:0] ev;
        logic [7:0] exp;
    } cef_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic go = 1'b0;
    logic [23:0] evp = 24'h0;
    logic [23:0] ev;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic erq;
    logic [7:0] flags;
    logic [1:0] mode;
    logic irq;
    int num_errors = 0;
    int samples_checked = 0;
    // Mode, event pattern, expected flags
    cef_row_t rows[14] = '{
        '{2'h0, 24'h800000, 8'h80},
        '{2'h0, 24'h400000, 8'h40},
        '{2'h0, 24'h100000, 8'h20},
        '{2'h0, 24'h020000, 8'h10},
        '{2'h0, 24'h010000, 8'h08},
        '{2'h0, 24'h008000, 8'h04},
        '{2'h0, 24'h004000, 8'h02},
        '{2'h0, 24'h002000, 8'h01},
        '{2'h0, 24'hFFFFFF, 8'hFF},
        '{2'h1, 24'h001000, 8'h10},
        '{2'h1, 24'h000002, 8'h02},
        '{2'h1, 24'hFFFFFF, 8'hF2},
        '{2'h2, 24'h000001, 8'h01},
        '{2'h2, 24'hFFFFFF, 8'hF3}};
    cef_can_model u_can (.i_clk(clk), .i_rst(rst), .i_go(go),
        .i_ev(evp), .o_ev(ev));
    cef_flag_reg uut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
        .I_PWDATA(pwdata), .I_PSTRB(pstrb), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_INVALID_MSG(ev[23]), .I_BUS_WAKE(ev[22]),
        .I_MODULE_ERR(ev[21:18]), .I_TX_DONE(ev[17:15]),
        .I_RX_NEW(ev[14:13]), .I_PRG_TX_DONE(ev[12:7]),
        .I_PRG_RX_NEW(ev[6:1]), .I_FIFO_WM(ev[0]),
        .O_CAN_IRQ_FLAGS(flags), .O_CAN_MODE(mode), .O_IRQ(irq));
    initial begin
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        samples_checked++;
        if (got !== e) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, 32'h1);
        rd = prdata;
        erq = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic fire(input logic [23:0] p);
        go <= 1'b1;
        evp <= p;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        chk(32'h0, 32'h1);
        test_done;
    end
    ////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(1'b1, 12'h008, {30'h0, rows[i].m});
            apb(1'b1, 12'h000, 32'h0);
            fire(rows[i].ev);
            chk({24'h0, flags}, {24'h0, rows[i].exp});
            rdchk(12'h000, {24'h0, rows[i].exp});
        end
        $display("table rows done");
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b1, 12'h000, 32'h5A);
        rdchk(12'h000, 32'h5A);
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 32'hFF);
        pstrb <= 4'hF;
        rdchk(12'h000, 32'h5A);
        apb(1'b1, 12'h000, 32'hFF);
        apb(1'b1, 12'h008, 32'h1);
        chk({30'h0, mode}, 32'h1);
        rdchk(12'h000, 32'hF2);
        apb(1'b1, 12'h008, 32'h2);
        apb(1'b1, 12'h000, 32'hFF);
        rdchk(12'h000, 32'hF3);
        apb(1'b1, 12'h008, 32'h3);
        chk({30'h0, mode}, 32'h2);
        rdchk(12'h008, 32'h2);
        $display("mode change done");
        apb(1'b1, 12'h004, 32'h80);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 12'h004, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 12'h004, 32'h20);
        rdchk(12'h00C, 32'h20);
        apb(1'b1, 12'h000, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rdchk(12'h010, 32'h0);
        chk({31'h0, erq}, 32'h1);
        $display("interrupt and map done");
        apb(1'b1, 12'h000, 32'hFF);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk({24'h0, flags}, 32'h0);
        rst <= 1'b0;
        @(posedge clk);
        rdchk(12'h000, 32'h0);
        rdchk(12'h004, 32'h0);
        rdchk(12'h008, 32'h0);
        $display("reset done");
        test_done;
    end
endmodule
bind cef_flag_reg cef_flag_reg_chk u_chk (.I_SYS_CLK, .I_SYS_RST, .I_PSEL,
    .I_PENABLE, .I_PWRITE, .O_PREADY, .I_INVALID_MSG, .I_MODULE_ERR,
    .I_TX_DONE, .I_PRG_TX_DONE, .I_FIFO_WM, .O_CAN_IRQ_FLAGS, .O_CAN_MODE);
